// ===== rps_pkg.sv
package rps_pkg;

    // Oscillator clock period in picoseconds.
    localparam int unsigned CLK_PERIOD_PS = 5000;

    // Pin low time after supplies settle, in microseconds, and its cycle count.
    localparam int unsigned POR_LOW_US = 100;
    localparam int unsigned POR_LOW_CYC = (POR_LOW_US * 1000000) / CLK_PERIOD_PS;

    // Watchdog reset pulse length in oscillator clock cycles.
    localparam int unsigned WDOG_LOW_CYC = 512;

    // Boot-mode pin hold window, in microseconds (1.5 ms), and its cycle count.
    localparam int unsigned BOOT_HOLD_US = 1500;
    localparam int unsigned BOOT_HOLD_CYC = (BOOT_HOLD_US * 1000000) / CLK_PERIOD_PS;

    // Width of the shared pulse counter.
    localparam int unsigned CNT_W = 20;

    // Number of boot-mode pins.
    localparam int unsigned BOOT_W = 2;

    // Reset source codes for the cause report.
    localparam logic [2:0] SRC_PIN = 3'h0;
    localparam logic [2:0] SRC_WDOG = 3'h1;
    localparam logic [2:0] SRC_NMIWD = 3'h2;
    localparam logic [2:0] SRC_SYS = 3'h3;
    localparam logic [2:0] SRC_DBG = 3'h4;
    localparam logic [2:0] SRC_HIB = 3'h5;

    // Internal reset requests gathered together.
    typedef struct packed {
        logic watchdog_reset;
        logic nmi_watchdog_reset;
        logic system_software_reset;
        logic debug_core_reset;
        logic hibernate_wake_reset;
    } rps_req_s;

    // Sequencer states, one-hot.
    typedef enum logic [4:0] {
        ST_POWERUP = 5'h01,
        ST_STRETCH = 5'h02,
        ST_PINWAIT = 5'h04,
        ST_HOLD = 5'h08,
        ST_RUN = 5'h10
    } rps_state_e;

endpackage : rps_pkg

// ===== rps_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser; the first stage feeds only the second.
module rps_sync
    import rps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_d,
    output logic o_q
);

    logic meta_r;
    logic q_r;

    // Both stages preset high so a released pin reads idle after reset.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            meta_r <= 1'b1;
            q_r <= 1'b1;
        end
        else
        begin
            meta_r <= i_d;
            q_r <= meta_r;
        end
    end

    assign o_q = q_r;

endmodule : rps_sync

`default_nettype wire

// ===== rps_reset_pin_sequencer.sv
// Functional notes
// - Reset pin is input and open-drain output.
// - Power-on reset holds pin low.
// - Pin held low 100 us after supplies.
// - Watchdog and NMI watchdog pull pin low.
// - Watchdog pulse lasts 512 oscillator cycles.
// - Six sources; hold window after each.
// - Debug core reset leaves pin alone.
// - Sample boot pins after any reset.
// - I/Os high-impedance during power-up.
// - Hovering supply may repeat reset pulses.
`timescale 1ns/1ps
`default_nettype none

module rps_reset_pin_sequencer
    import rps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_supply_ok,
    input wire logic i_device_reset_n_pin,
    input wire rps_req_s i_req,
    input wire logic [BOOT_W-1:0] i_boot_pins,
    output logic o_device_reset_n_pin,
    output logic o_device_reset_n_pin_oe_n,
    output logic o_io_hiz,
    output logic o_core_reset_n,
    output logic o_boot_hold,
    output logic o_boot_valid,
    output logic [BOOT_W-1:0] o_boot_mode,
    output logic [2:0] o_reset_cause
);

    // Synchronised copy of the reset pin level.
    logic pin_sync;

    rps_sync u_pin_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_d(i_device_reset_n_pin),
        .o_q(pin_sync)
    );

    rps_state_e state_r;
    rps_state_e state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic drive_r;
    logic drive_nxt;
    // Pin enable kept in its own flop so the pad sees no gate after the register.
    logic oe_n_r;
    logic oe_n_nxt;
    logic hiz_r;
    logic hiz_nxt;
    logic core_n_r;
    logic core_n_nxt;
    logic hold_r;
    logic hold_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [BOOT_W-1:0] bmode_r;
    logic [BOOT_W-1:0] bmode_nxt;
    logic [2:0] cause_r;
    logic [2:0] cause_nxt;

    // Watchdog-class requests pull the pin; debug core reset does not.
    logic wd_any;
    logic quiet_any;
    assign wd_any = i_req.watchdog_reset | i_req.nmi_watchdog_reset;
    assign quiet_any = i_req.debug_core_reset | i_req.system_software_reset
                     | i_req.hibernate_wake_reset;

    // Next-state logic for the whole sequencer.
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        drive_nxt = drive_r;
        hiz_nxt = hiz_r;
        core_n_nxt = core_n_r;
        hold_nxt = hold_r;
        bvalid_nxt = bvalid_r;
        bmode_nxt = bmode_r;
        cause_nxt = cause_r;
        if (!i_supply_ok)
        begin
            // A sagging supply restarts power-up; repeated dips repeat pulses.
            state_nxt = ST_POWERUP;
            drive_nxt = 1'b1;
            hiz_nxt = 1'b1;
            core_n_nxt = 1'b0;
            hold_nxt = 1'b0;
            bvalid_nxt = 1'b0;
            cnt_nxt = '0;
        end
        else
        begin
            unique case (state_r)
                ST_POWERUP:
                begin
                    // Supplies are up: keep the pin low for the power-on stretch.
                    state_nxt = ST_STRETCH;
                    cnt_nxt = CNT_W'(POR_LOW_CYC - 1);
                    cause_nxt = SRC_PIN;
                end
                ST_STRETCH:
                begin
                    if (cnt_r == '0)
                    begin
                        drive_nxt = 1'b0;
                        state_nxt = ST_PINWAIT;
                    end
                    else
                    begin
                        cnt_nxt = cnt_r - 1'b1;
                    end
                end
                ST_PINWAIT:
                begin
                    // Internal reset is freed only once the pin reads high again,
                    // so an external holder keeps the core in reset.
                    if (pin_sync)
                    begin
                        hiz_nxt = 1'b0;
                        core_n_nxt = 1'b1;
                        hold_nxt = 1'b1;
                        // Boot pins are taken at release, inside the window in which
                        // they must stand still, not at its far end.
                        bvalid_nxt = 1'b1;
                        bmode_nxt = i_boot_pins;
                        cnt_nxt = CNT_W'(BOOT_HOLD_CYC - 1);
                        state_nxt = ST_HOLD;
                    end
                end
                ST_HOLD, ST_RUN:
                begin
                    // The boot window runs down while new resets are already taken,
                    // so a long window never blocks a watchdog or a pin reset.
                    if (state_r == ST_HOLD)
                    begin
                        if (cnt_r == '0)
                        begin
                            hold_nxt = 1'b0;
                            state_nxt = ST_RUN;
                        end
                        else
                        begin
                            cnt_nxt = cnt_r - 1'b1;
                        end
                    end
                    // Sources in priority order; the pin reset comes first.
                    if (!pin_sync)
                    begin
                        cause_nxt = SRC_PIN;
                        hold_nxt = 1'b0;
                        state_nxt = ST_PINWAIT;
                        core_n_nxt = 1'b0;
                        bvalid_nxt = 1'b0;
                    end
                    else if (wd_any)
                    begin
                        cause_nxt = i_req.watchdog_reset ? SRC_WDOG : SRC_NMIWD;
                        drive_nxt = 1'b1;
                        cnt_nxt = CNT_W'(WDOG_LOW_CYC - 1);
                        hold_nxt = 1'b0;
                        state_nxt = ST_STRETCH;
                        core_n_nxt = 1'b0;
                        bvalid_nxt = 1'b0;
                    end
                    else if (quiet_any)
                    begin
                        // Internal-only reset: pin stays released.
                        cause_nxt = i_req.system_software_reset ? SRC_SYS :
                                    i_req.debug_core_reset ? SRC_DBG : SRC_HIB;
                        hold_nxt = 1'b0;
                        state_nxt = ST_PINWAIT;
                        core_n_nxt = 1'b0;
                        bvalid_nxt = 1'b0;
                    end
                end
            endcase
        end
        // The enable is active low and follows the pull request.
        oe_n_nxt = ~drive_nxt;
    end

    // Registers; reset lands in power-up with the pin pulled low.
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state_r <= ST_POWERUP;
            cnt_r <= '0;
            drive_r <= 1'b1;
            oe_n_r <= 1'b0;
            hiz_r <= 1'b1;
            core_n_r <= 1'b0;
            hold_r <= 1'b0;
            bvalid_r <= 1'b0;
            bmode_r <= '0;
            cause_r <= SRC_PIN;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            drive_r <= drive_nxt;
            oe_n_r <= oe_n_nxt;
            hiz_r <= hiz_nxt;
            core_n_r <= core_n_nxt;
            hold_r <= hold_nxt;
            bvalid_r <= bvalid_nxt;
            bmode_r <= bmode_nxt;
            cause_r <= cause_nxt;
        end
    end

    // Open drain: data is always low, enable low means driving.
    assign o_device_reset_n_pin = 1'b0;
    assign o_device_reset_n_pin_oe_n = oe_n_r;
    assign o_io_hiz = hiz_r;
    assign o_core_reset_n = core_n_r;
    assign o_boot_hold = hold_r;
    assign o_boot_valid = bvalid_r;
    assign o_boot_mode = bmode_r;
    assign o_reset_cause = cause_r;

    // Counts consecutive driven cycles to check stretch lengths.
    logic [CNT_W-1:0] low_run_r;
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            low_run_r <= '0;
        else
            low_run_r <= drive_r ? low_run_r + 1'b1 : '0;
    end

    a_wdog_pulse_len: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $rose(drive_r) && i_supply_ok |-> ##1 (drive_r && i_supply_ok)[*8] ##0 1'b1
        or ##[1:9] !i_supply_ok) else $error("watchdog pulse too short");
    a_wdog_drives: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (state_r == ST_RUN || state_r == ST_HOLD) && i_supply_ok && pin_sync && wd_any
        |=> drive_r) else $error("watchdog did not pull pin");
    a_dbg_quiet: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (state_r == ST_RUN || state_r == ST_HOLD) && i_supply_ok && pin_sync && !wd_any
        && quiet_any |=> !drive_r) else $error("debug reset pulled pin");
    a_por_drive: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !i_supply_ok |=> drive_r && hiz_r) else $error("power-up pin not low");
    a_hiz_up: assert property (@(posedge i_clk) disable iff (!i_nrst)
        drive_r |-> hiz_r || state_r == ST_STRETCH) else $error("io not hiz");
    a_por_stretch: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $fell(drive_r) |-> low_run_r >= ((cause_r == SRC_PIN) ? CNT_W'(POR_LOW_CYC)
        : CNT_W'(WDOG_LOW_CYC))) else $error("stretch released early");
    a_core_sync: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $rose(core_n_r) |-> $past(pin_sync)) else $error("release not synced");
    a_boot_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $rose(core_n_r) |-> hold_r ##1 hold_r[*8]) else $error("hold too short");
    a_boot_sample: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $rose(bvalid_r) |-> o_boot_mode == $past(i_boot_pins))
        else $error("boot pins not sampled");

endmodule : rps_reset_pin_sequencer

`default_nettype wire

// ===== rps_far_side.sv
`timescale 1ns/1ps
`default_nettype none

// Board around the reset pin: pull-up, supply supervisor and boot-pin driver.
module rps_far_side
    import rps_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_supply_ok,
    input wire logic i_warm_req,
    input wire logic i_dev_oe_n,
    input wire logic [BOOT_W-1:0] i_boot_val,
    output logic o_pin,
    output logic [BOOT_W-1:0] o_boot_pins
);
    // Divider of the system clock in low-power use; 16 or less keeps the base time.
    localparam int SYSTEM_CLOCK_DIVIDER = 16;
    // A warm reset is never shorter than 3.2 us, 640 cycles at 5 ns, scaled by
    // divider / 16 once the divider goes above 16.
    localparam int WARM_MIN_CYC = (SYSTEM_CLOCK_DIVIDER > 16) ?
        (640 * SYSTEM_CLOCK_DIVIDER) / 16 : 640;
    int hold_cnt = 0;

    // Keeps the pin low for the minimum low time after every warm request ends.
    always @(posedge i_clk)
    begin
        if (i_warm_req)
            hold_cnt <= WARM_MIN_CYC;
        else if (hold_cnt > 0)
            hold_cnt <= hold_cnt - 1;
    end

    // Wired-AND pin: the pull-up wins only when nobody pulls low.
    assign o_pin = !(!i_dev_oe_n || !i_supply_ok || i_warm_req || hold_cnt > 0);
    // Drivers let go while the pin is low, so the pins fall back to pull-ups.
    assign o_boot_pins = o_pin ? i_boot_val : {BOOT_W{1'b1}};
endmodule : rps_far_side

`default_nettype wire

// ===== reset_pin_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none

module reset_pin_sequencer_tb
    import rps_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic supply_ok = 1'b0;
    logic warm = 1'b0;
    rps_req_s req = '0;
    logic [BOOT_W-1:0] boot_val = '0;
    logic pin, pin_q, oe_n, hiz, core_n, hold, valid;
    logic [BOOT_W-1:0] boot_pins, mode;
    logic [2:0] cause;
    int error_cnt = 0;
    int checks_done = 0;

    // Free-running 200 MHz clock.
    initial
    begin
        forever #2.5 clk = ~clk;
    end

    rps_reset_pin_sequencer i_rps_reset_pin_sequencer (.i_clk(clk), .i_nrst(nrst),
        .i_supply_ok(supply_ok), .i_device_reset_n_pin(pin), .i_req(req),
        .i_boot_pins(boot_pins), .o_device_reset_n_pin(pin_q),
        .o_device_reset_n_pin_oe_n(oe_n), .o_io_hiz(hiz), .o_core_reset_n(core_n),
        .o_boot_hold(hold), .o_boot_valid(valid), .o_boot_mode(mode), .o_reset_cause(cause));

    rps_far_side i_rps_far_side (.i_clk(clk), .i_supply_ok(supply_ok), .i_warm_req(warm),
        .i_dev_oe_n(oe_n), .i_boot_val(boot_val), .o_pin(pin), .o_boot_pins(boot_pins));

    // Selects the output that a wait watches.
    function automatic logic mon(input int k);
        case (k)
            0: return oe_n;
            1: return core_n;
            default: return hold;
        endcase
    endfunction : mon

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    // Bounded wait for a level; a hang counts as a mismatch and ends the run.
    task automatic wait_lvl(input int k, input logic lvl, input int lim, output int n);
        n = 0;
        while (mon(k) !== lvl)
        begin
            @(posedge clk);
            #1;
            n++;
            if (n > lim)
            begin
                error_cnt++;
                $display("CHECK FAILED wait %0d expected %0h seen timeout", k, lvl);
                summarize();
            end
        end
    endtask : wait_lvl

    // Mode and cause at release, then the hold window still open a while later.
    // The full 1.5 ms window is far longer than the run may last, so only its
    // opening stretch is watched here.
    task automatic boot_end(input logic [2:0] src);
        chk("hold up", 1'b1, hold);
        chk("valid", 1'b1, valid);
        chk("mode", boot_val, mode);
        chk("cause", src, cause);
        chk("io live", 1'b0, hiz);
        repeat (1000 + $urandom_range(0, 500)) @(posedge clk);
        #1;
        chk("hold len", 1'b1, hold);
    endtask : boot_end

    // Pulses one request for one cycle; the boot pins move only once it is taken,
    // and the task returns just after the edge at which the design takes it.
    task automatic pulse(input int k);
        @(posedge clk);
        req <= rps_req_s'(5'h10 >> k);
        @(posedge clk);
        req <= '0;
        boot_val <= BOOT_W'($urandom);
        #1;
    endtask : pulse

    initial
    begin
        int n;
        int ext;
        void'($urandom(32'h37877ce3));
        boot_val <= BOOT_W'($urandom);
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk("por pull", 1'b0, oe_n);
        chk("pin data", 1'b0, pin_q);
        chk("io hiz", 1'b1, hiz);
        repeat (1 + $urandom_range(0, 20)) @(posedge clk);
        supply_ok <= 1'b1;
        warm <= 1'b1;
        wait_lvl(0, 1'b1, POR_LOW_CYC + 4, n);
        chk("por len", 1'b1, n >= POR_LOW_CYC && n <= POR_LOW_CYC + 2);
        ext = 50 + $urandom_range(0, 300);
        repeat (ext) @(posedge clk);
        #1;
        chk("core held", 1'b0, core_n);
        @(posedge clk);
        warm <= 1'b0;
        wait_lvl(1, 1'b1, 700, n);
        chk("pin release", 1'b1, n >= 640 && n <= 650);
        boot_end(SRC_PIN);
        $display("TEST power-on done");
        pulse(0);
        chk("wdog pull", 1'b0, oe_n);
        wait_lvl(0, 1'b1, WDOG_LOW_CYC + 4, n);
        chk("wdog len", WDOG_LOW_CYC, n);
        wait_lvl(1, 1'b1, 8, n);
        boot_end(SRC_WDOG);
        $display("TEST watchdog done");
        pulse(3);
        chk("dbg core", 1'b0, core_n);
        for (int i = 0; i < 600; i++)
        begin
            @(posedge clk);
            #1;
            chk("dbg no pull", 1'b1, oe_n);
        end
        wait_lvl(1, 1'b1, 8, n);
        boot_end(SRC_DBG);
        $display("TEST debug done");
        pulse(1);
        chk("nmi pull", 1'b0, oe_n);
        chk("nmi cause", SRC_NMIWD, cause);
        repeat ($urandom_range(1, 400)) @(posedge clk);
        supply_ok <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("drop pull", 1'b0, oe_n);
        chk("drop hiz", 1'b1, hiz);
        chk("drop pin", 1'b0, pin);
        chk("drop core", 1'b0, core_n);
        $display("TEST supply drop done");
        summarize();
    end
endmodule : reset_pin_sequencer_tb

`default_nettype wire
